// file: vsc_pkg.sv
`default_nettype none
package vsc_pkg;
    localparam int ADDR_W      = 9;      // Multiplexed row/column address
    localparam int DQ_W        = 8;      // Parallel and serial word width
    localparam int FIFO_DEPTH  = 32;     // Serial write buffer depth
    localparam int CLK_NS      = 100;    // System clock period
    localparam int SC_HALF_NS  = 400;    // Serial clock half period
    // Longest half period rounds down, never below one cycle
    localparam int SC_HALF_CYC = (SC_HALF_NS / CLK_NS) < 1 ? 1
                                 : (SC_HALF_NS / CLK_NS);
    localparam int BLK_LSB_W   = 2;      // Column bits ignored by a fill
    localparam logic [BLK_LSB_W-1:0] BLK_LSB_ZERO = 2'h0;
    localparam logic [DQ_W-1:0]      DQ_ZERO      = 8'h00;

    typedef enum logic [2:0] {
        OP_WRITE, OP_MASK_NP, OP_MASK_P, OP_LOAD_MASK, OP_LOAD_COLOR,
        OP_BLOCK
    } vsc_op_t;

    typedef struct packed {
        vsc_op_t             op;
        logic                mask_en;   // Fill with a fresh row mask
        logic [ADDR_W-1:0]   row;
        logic [ADDR_W-1:0]   col;
        logic [DQ_W-1:0]     data;      // Write data, or column enables
        logic [DQ_W-1:0]     mask;      // Plane mask given at row strobe
    } vsc_cmd_t;

    typedef struct packed {
        logic                ras_n;
        logic                cas_n;
        logic                we_n;
        logic                special_function_select;
        logic                trg_n;     // Transfer/output enable, held high
        logic [ADDR_W-1:0]   addr;
    } vsc_pins_t;

    // Write strobe level at the falling row strobe: low picks masking
    function automatic logic ras_we_n(input vsc_cmd_t c);
        ras_we_n = !(c.op == OP_MASK_NP || c.op == OP_MASK_P
                     || (c.op == OP_BLOCK && c.mask_en));
    endfunction

    // Special-function select at the falling row strobe
    function automatic logic ras_dsf(input vsc_cmd_t c);
        ras_dsf = (c.op == OP_MASK_P || c.op == OP_LOAD_MASK
                   || c.op == OP_LOAD_COLOR);
    endfunction

    // Special-function select at the falling column strobe
    function automatic logic cas_dsf(input vsc_cmd_t c);
        cas_dsf = (c.op == OP_LOAD_COLOR || c.op == OP_BLOCK);
    endfunction

    // Parallel pins carry a fresh mask at the falling row strobe
    function automatic logic ras_dq(input vsc_cmd_t c);
        ras_dq = (c.op == OP_MASK_NP || (c.op == OP_BLOCK && c.mask_en));
    endfunction
endpackage
`default_nettype wire

// file: vsc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module vsc_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         clk,       // System clock
    input  wire logic         arst_n,    // Asynchronous reset
    input  wire logic         in_valid,  // Word offered
    input  wire logic [W-1:0] in_data,   // Word to store
    output logic              in_ready,  // Room for a word
    output logic              out_valid, // Word available
    output logic [W-1:0]      out_data,  // Oldest word
    input  wire logic         out_ready  // Oldest word taken
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] DEPTH = (AW+1)'(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    // Pointers wrap at the depth; count drives full and empty honestly
    always_comb begin
        push  = in_valid && in_ready;
        pop   = out_valid && out_ready;
        wr_d  = push ? ((wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d  = pop ? ((rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q     <= '0;
            rd_q     <= '0;
            cnt_q    <= '0;
            in_ready <= 1'b0;
        end else begin
            wr_q     <= wr_d;
            rd_q     <= rd_d;
            cnt_q    <= cnt_d;
            in_ready <= cnt_d != DEPTH;
        end
    end

    // Storage has no reset; words are read only once written
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rd_q];
endmodule

module vsc_ctrl
    import vsc_pkg::*;
(
    input  wire logic            clk,        // 10 MHz system clock
    input  wire logic            arst_n,     // Asynchronous reset
    input  wire logic            cmd_valid,  // Array command offered
    input  wire vsc_cmd_t        cmd,        // Array command
    output logic                 cmd_ready_q, // Ready for a command, high while idle
    output logic                 cmd_err_q,  // Command refused, one pulse
    input  wire logic            ser_run,    // Keep the serial clock going
    input  wire logic            ser_to_dev, // Buffer set for input
    input  wire logic            wr_valid,   // Serial word offered
    input  wire logic [DQ_W-1:0] wr_data,    // Serial word to device
    output logic                 wr_ready,   // Serial FIFO has room
    output logic                 rd_valid_q, // Serial word read, one pulse
    output logic [DQ_W-1:0]      rd_data_q,  // Serial word from device
    output logic                 half_q,     // Active buffer half
    output logic                 half_cross_q, // Half change, one pulse
    output vsc_pins_t            pins_q,     // Array strobes and address
    output logic [DQ_W-1:0]      dq_out_q,   // Parallel data out
    output logic                 dq_oe_q,    // Parallel drive enable
    output logic                 sc_q,       // Serial shift clock
    output logic                 sen_n_q,    // Serial enable, low active
    output logic [DQ_W-1:0]      sdq_out_q,  // Serial data out
    output logic                 sdq_oe_q,   // Serial drive enable
    input  wire logic [DQ_W-1:0] sdq_in,     // Serial data pins
    input  wire logic            half_in     // Buffer half flag pin
);
    typedef enum logic [2:0] {
        D_IDLE, D_SETUP, D_ROW, D_COL, D_CAS, D_END
    } vsc_dst_t;
    typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH} vsc_sst_t;
    localparam logic [7:0] HALF_LAST = 8'(SC_HALF_CYC - 1);

    vsc_dst_t        dst_q, dst_d;
    vsc_cmd_t        cur_q, cur_d;
    vsc_pins_t       pins_d;
    logic [DQ_W-1:0] dq_out_d;
    logic            dq_oe_d, rdy_d, err_d;
    logic            color_ok_q, color_ok_d, mask_ok_q, mask_ok_d;

    // Array cycle: setup, row strobe, column setup, column strobe, end
    always_comb begin
        dst_d      = dst_q;
        cur_d      = cur_q;
        err_d      = 1'b0;
        color_ok_d = color_ok_q;
        mask_ok_d  = mask_ok_q;
        case (dst_q)
            D_IDLE: begin
                if (cmd_valid && cmd_ready_q) begin
                    // Stored registers are garbage until loaded
                    if ((cmd.op == OP_BLOCK && !color_ok_q)
                        || (cmd.op == OP_MASK_P && !mask_ok_q)) begin
                        err_d = 1'b1;
                    end else begin
                        cur_d = cmd;
                        dst_d = D_SETUP;
                    end
                end
            end
            D_SETUP: dst_d = D_ROW;
            D_ROW:   dst_d = D_COL;
            D_COL:   dst_d = D_CAS;
            D_CAS: begin
                dst_d = D_END;
                if (cur_q.op == OP_LOAD_COLOR) color_ok_d = 1'b1;
                if (cur_q.op == OP_LOAD_MASK)  mask_ok_d  = 1'b1;
            end
            D_END:   dst_d = D_IDLE;
            default: dst_d = D_IDLE;
        endcase
        rdy_d = dst_d == D_IDLE;
    end

    // Pin levels follow the next state so every pin leaves a flip-flop
    always_comb begin
        pins_d   = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, special_function_select: 1'b0,
                     trg_n: 1'b1, addr: pins_q.addr};
        dq_out_d = DQ_ZERO;
        dq_oe_d  = 1'b0;
        case (dst_d)
            D_SETUP, D_ROW: begin
                pins_d.ras_n = dst_d != D_ROW;
                pins_d.addr  = cur_d.row;
                pins_d.we_n  = ras_we_n(cur_d);
                pins_d.special_function_select   = ras_dsf(cur_d);
                dq_oe_d      = ras_dq(cur_d);
                dq_out_d     = cur_d.mask;
            end
            D_COL, D_CAS: begin
                pins_d.ras_n = 1'b0;
                pins_d.cas_n = dst_d != D_CAS;
                pins_d.we_n  = 1'b0;
                pins_d.special_function_select   = cas_dsf(cur_d);
                pins_d.addr  = cur_d.col;
                if (cur_d.op == OP_BLOCK) begin
                    pins_d.addr[BLK_LSB_W-1:0] = BLK_LSB_ZERO;
                end
                dq_oe_d  = 1'b1;
                dq_out_d = cur_d.data;
            end
            default: begin
                pins_d.ras_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dst_q       <= D_IDLE;
            cur_q       <= '0;
            cmd_ready_q <= 1'b0;
            cmd_err_q   <= 1'b0;
            color_ok_q  <= 1'b0;
            mask_ok_q   <= 1'b0;
            pins_q      <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                             special_function_select: 1'b0, trg_n: 1'b1, addr: '0};
            dq_out_q    <= '0;
            dq_oe_q     <= 1'b0;
        end else begin
            dst_q       <= dst_d;
            cur_q       <= cur_d;
            cmd_ready_q <= rdy_d;
            cmd_err_q   <= err_d;
            color_ok_q  <= color_ok_d;
            mask_ok_q   <= mask_ok_d;
            pins_q      <= pins_d;
            dq_out_q    <= dq_out_d;
            dq_oe_q     <= dq_oe_d;
        end
    end

    // Serial side: two-flop synchronisers for pins driven by the device
    logic [DQ_W-1:0] sdq_m_q, sdq_s_q;
    logic            half_m_q, half_s_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sdq_m_q  <= '0;
            sdq_s_q  <= '0;
            half_m_q <= 1'b0;
            half_s_q <= 1'b0;
        end else begin
            sdq_m_q  <= sdq_in;
            sdq_s_q  <= sdq_m_q;
            half_m_q <= half_in;
            half_s_q <= half_m_q;
        end
    end

    logic            f_valid, f_ready;
    logic [DQ_W-1:0] f_data;

    // Buffer lets the source run ahead of the slow shift clock
    vsc_fifo #(.W(DQ_W), .D(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (wr_valid),
        .in_data   (wr_data),
        .in_ready  (wr_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_ready)
    );

    vsc_sst_t        sst_q, sst_d;
    logic [7:0]      cnt_q, cnt_d;
    logic            sc_d, sen_n_d, sdq_oe_d, rd_valid_d, half_d;
    logic [DQ_W-1:0] sdq_out_d, rd_data_d;
    logic            tick;

    // Divider makes the shift clock; both half periods are equal
    always_comb begin
        tick       = cnt_q == HALF_LAST;
        cnt_d      = (sst_q == S_IDLE || tick) ? 8'h00 : cnt_q + 8'h01;
        sst_d      = sst_q;
        sc_d       = sc_q;
        sen_n_d    = sen_n_q;
        sdq_out_d  = sdq_out_q;
        sdq_oe_d   = sdq_oe_q;
        rd_valid_d = 1'b0;
        rd_data_d  = rd_data_q;
        f_ready    = 1'b0;
        half_d     = half_s_q;
        case (sst_q)
            S_IDLE: begin
                sc_d     = 1'b0;
                sen_n_d  = 1'b1;
                sdq_oe_d = 1'b0;
                if (ser_run) begin
                    sst_d = S_LOW;
                    // Word is set up a full half period before the rise
                    sdq_oe_d = ser_to_dev;
                    sen_n_d  = ser_to_dev && !f_valid;
                    f_ready  = ser_to_dev;
                    sdq_out_d = f_data;
                end
            end
            S_LOW: begin
                if (tick) begin
                    sst_d = S_HIGH;
                    sc_d  = 1'b1;
                    // Device word of the previous rise is settled now
                    rd_valid_d = !ser_to_dev && !sen_n_q;
                    rd_data_d  = sdq_s_q;
                end
            end
            S_HIGH: begin
                if (tick) begin
                    sc_d = 1'b0;
                    if (ser_run) begin
                        sst_d     = S_LOW;
                        sdq_oe_d  = ser_to_dev;
                        sen_n_d   = ser_to_dev && !f_valid;
                        f_ready   = ser_to_dev;
                        sdq_out_d = f_data;
                    end else begin
                        sst_d    = S_IDLE;
                        sen_n_d  = 1'b1;
                        sdq_oe_d = 1'b0;
                    end
                end
            end
            default: sst_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sst_q        <= S_IDLE;
            cnt_q        <= 8'h00;
            sc_q         <= 1'b0;
            sen_n_q      <= 1'b1;
            sdq_out_q    <= '0;
            sdq_oe_q     <= 1'b0;
            rd_valid_q   <= 1'b0;
            rd_data_q    <= '0;
            half_q       <= 1'b0;
            half_cross_q <= 1'b0;
        end else begin
            sst_q        <= sst_d;
            cnt_q        <= cnt_d;
            sc_q         <= sc_d;
            sen_n_q      <= sen_n_d;
            sdq_out_q    <= sdq_out_d;
            sdq_oe_q     <= sdq_oe_d;
            rd_valid_q   <= rd_valid_d;
            rd_data_q    <= rd_data_d;
            half_q       <= half_d;
            half_cross_q <= half_d != half_q;
        end
    end

    logic [7:0]      hi_cnt_q, hi_cnt_d;

    // Assertion helper: cycles the shift clock has stood high so far
    always_comb begin
        hi_cnt_d = sc_q ? hi_cnt_q + 8'h01 : 8'h00;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt_q <= 8'h00;
        end else begin
            hi_cnt_q <= hi_cnt_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sc_parked_low_a: assert property (sst_q == S_IDLE |-> !sc_q)
        else $error("serial clock not parked low");
    dsf_idle_zero_a: assert property (dst_q == D_IDLE |-> !pins_q.special_function_select)
        else $error("special select high while idle");
    fill_we_early_a: assert property ($fell(pins_q.cas_n)
        && cur_q.op == OP_BLOCK |-> !pins_q.we_n && !$past(pins_q.we_n))
        else $error("fill write strobe not early");
    fill_color_ok_a: assert property (dst_q == D_SETUP
        && cur_q.op == OP_BLOCK |-> color_ok_q)
        else $error("fill before colour load");
    fill_lsb_zero_a: assert property (!pins_q.cas_n
        && cur_q.op == OP_BLOCK |-> pins_q.addr[BLK_LSB_W-1:0] == BLK_LSB_ZERO)
        else $error("fill column low bits set");
    np_mask_ras_a: assert property ($fell(pins_q.ras_n)
        && cur_q.op == OP_MASK_NP |-> dq_oe_q && dq_out_q == cur_q.mask
        && $past(dq_oe_q))
        else $error("fresh mask missing at row strobe");
    row_ends_a: assert property ($fell(pins_q.cas_n)
        |=> pins_q.ras_n && pins_q.cas_n && !dq_oe_q)
        else $error("row cycle did not end");
    skip_empty_a: assert property (f_ready && !f_valid |=> sen_n_q)
        else $error("empty buffer cycle not skipped");
    word_pop_a: assert property (f_ready && f_valid
        |=> !sen_n_q && sdq_oe_q && sdq_out_q == $past(f_data))
        else $error("popped word not driven");
    half_pulse_a: assert property (half_cross_q |-> half_q != $past(half_q))
        else $error("half change pulse without change");
    sc_half_a: assert property ($fell(sc_q)
        |-> hi_cnt_q == HALF_LAST + 8'h01)
        else $error("serial clock high phase wrong length");

    fill_cov_c:  cover property (dst_q == D_CAS && cur_q.op == OP_BLOCK);
    lmask_cov_c: cover property (dst_q == D_CAS && cur_q.op == OP_LOAD_MASK);
    ser_cov_c:   cover property ($rose(sc_q) && !sen_n_q && sdq_oe_q);
endmodule
`default_nettype wire

// file: vsc_vram_model.sv
`timescale 1ns/1ps
`default_nettype none
module vsc_vram_model
    import vsc_pkg::*;
(
    input  wire vsc_pins_t       pins,   // Array strobes and address
    input  wire logic [DQ_W-1:0] dq,     // Parallel data from host
    input  wire logic            dq_oe,  // Host drives parallel pins
    input  wire logic            sc,     // Serial shift clock
    input  wire logic            sen_n,  // Serial enable, low active
    input  wire logic [DQ_W-1:0] sdq_o,  // Serial data from host
    input  wire logic            sdq_oe, // Host drives serial pins
    input  wire logic            to_dev, // Buffer set for input
    output logic [DQ_W-1:0]      sdq_in, // Serial data to host
    output logic                 half    // Active buffer half
);
    logic [DQ_W-1:0]   mem [int];      // Sparse array, key {row, col}
    logic [DQ_W-1:0]   sbuf [256];     // Serial line buffer
    logic [7:0]        ptr;            // Serial pointer
    logic [DQ_W-1:0]   mreg;           // Unknown until loaded
    logic [DQ_W-1:0]   creg;           // Unknown until loaded
    logic [DQ_W-1:0]   rmask;          // Mask of this row cycle
    logic [DQ_W-1:0]   dqv;            // Parallel pin level
    logic [ADDR_W-1:0] row;
    logic              rwe;
    logic              rdsf;
    int                viol;           // Fills issued with write high
    // Buffer holds its index so a read stream is easy to follow
    initial begin
        ptr = 8'h00;
        viol = 0;
        sdq_in = 8'h00;
        for (int k = 0; k < 256; k++) sbuf[k] = k[7:0];
    end
    assign half = ptr[7];
    assign dqv  = dq_oe ? dq : 'x;         // Released pins carry nothing
    // Masked store; an unwritten cell reads back unknown
    task automatic wr(input logic [ADDR_W-1:0] c, input logic [DQ_W-1:0] d);
        logic [DQ_W-1:0] o;
        o = mem.exists(int'({row, c})) ? mem[int'({row, c})] : 'x;
        mem[int'({row, c})] = (o & ~rmask) | (d & rmask);
    endtask
    // Row strobe picks the mode and the mask source
    always @(negedge pins.ras_n) begin
        row = pins.addr;
        rwe = pins.we_n;
        rdsf = pins.special_function_select;
        rmask = rwe ? 8'hff : (rdsf ? mreg : dqv);
    end
    always @(posedge pins.ras_n) rmask = 'x;
    // Column strobe: register loads, fills and plain writes
    always @(negedge pins.cas_n) begin
        if (rwe && rdsf) begin
            if (pins.special_function_select) creg = dqv;
            else mreg = dqv;
        end else if (pins.special_function_select) begin
            if (pins.we_n !== 1'b0) viol++;
            for (int j = 0; j < 4; j++)
                if (dqv[j]) wr({pins.addr[ADDR_W-1:2], j[1:0]}, creg);
        end else if (!pins.we_n) begin
            wr(pins.addr, dqv);
        end
    end
    // Falling edges do nothing; pointer moves on every rise
    always @(posedge sc) begin
        if (to_dev && !sen_n && sdq_oe) sbuf[ptr] = sdq_o;
        sdq_in <= #20 (to_dev || sen_n) ? ~sdq_in : sbuf[ptr];
        ptr <= #5 ptr + 8'h01;
    end
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import vsc_pkg::*;
    logic            clk = 1'b0;
    logic            arst_n = 1'b0;
    logic            cmd_valid = 1'b0;
    vsc_cmd_t        cmd = '0;
    logic            ser_run = 1'b0;
    logic            ser_to_dev = 1'b0;
    logic            wr_valid = 1'b0;
    logic [DQ_W-1:0] wr_data = 8'h80;
    logic            cmd_ready_q, cmd_err_q, wr_ready, rd_valid_q;
    logic            half_q, half_cross_q, dq_oe_q, sc_q, sen_n_q;
    logic            sdq_oe_q, half_in;
    logic [DQ_W-1:0] rd_data_q, dq_out_q, sdq_out_q, sdq_dev, sdq_in;
    vsc_pins_t       pins_q;
    int              err_total = 0;
    int              samples_checked = 0;
    int              i, n, p0;
    always #50 clk = ~clk;
    assign sdq_in = sdq_oe_q ? sdq_out_q : sdq_dev; // Shared serial pins
    vsc_ctrl vsc_ctrl_i (.clk, .arst_n, .cmd_valid, .cmd, .cmd_ready_q,
        .cmd_err_q, .ser_run, .ser_to_dev, .wr_valid, .wr_data, .wr_ready,
        .rd_valid_q, .rd_data_q, .half_q, .half_cross_q, .pins_q, .dq_out_q,
        .dq_oe_q, .sc_q, .sen_n_q, .sdq_out_q, .sdq_oe_q, .sdq_in, .half_in);
    vsc_vram_model vsc_vram_model_i (.pins(pins_q), .dq(dq_out_q),
        .dq_oe(dq_oe_q), .sc(sc_q), .sen_n(sen_n_q), .sdq_o(sdq_out_q),
        .sdq_oe(sdq_oe_q), .to_dev(ser_to_dev), .sdq_in(sdq_dev),
        .half(half_in));
    task automatic summarize();
        $display("mismatches %0d of %0d checks", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        err_total++;
        $display("BAD %0t wait ran out", $time);
        summarize();
    endtask
    task automatic mchk(input logic [8:0] r, c, input logic [7:0] e);
        int k;
        k = int'({r, c});
        chk(vsc_vram_model_i.mem.exists(k) ? vsc_vram_model_i.mem[k]
            : 8'hxx, e);
    endtask
    // One array command; a refusal may show on any of the next eight cycles
    task automatic run(input vsc_op_t op, input logic me,
                       input logic [8:0] r, c, input logic [7:0] d, m,
                       input logic e);
        logic seen;
        seen = 1'b0;
        cmd <= '{op, me, r, c, d, m};
        cmd_valid <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (cmd_ready_q === 1'b1) break;
        end
        if (i == 20) hang();
        cmd_valid <= 1'b0;
        repeat (8) begin
            @(posedge clk);
            seen |= (cmd_err_q === 1'b1);
        end
        chk(seen, e);
        for (i = 0; i < 20 && cmd_ready_q !== 1'b1; i++) @(posedge clk);
        if (i == 20) hang();
    endtask
    initial begin
        repeat (2) @(posedge clk);
        chk({pins_q.ras_n, pins_q.cas_n, sc_q, sen_n_q, cmd_ready_q}, 5'h1a);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // Read stream: first pulse has no device word yet, then 0, 1, 2...
        ser_run <= 1'b1;
        for (n = 0; n < 7; n++) begin
            for (i = 0; i < 100 && rd_valid_q !== 1'b1; i++) @(posedge clk);
            if (i == 100) hang();
            if (n > 0) chk(rd_data_q, n - 1);
            @(posedge clk);
        end
        ser_run <= 1'b0;
        repeat (30) @(posedge clk);
        repeat (16) begin @(posedge clk); chk(sc_q, 1'b0); end
        // Refusals first, then masks, registers and fills
        run(OP_MASK_P, 0, 9'h001, 9'h006, 8'hff, 8'h00, 1);
        run(OP_BLOCK, 0, 9'h002, 9'h000, 8'h0f, 8'h00, 1);
        run(OP_WRITE, 0, 9'h001, 9'h005, 8'ha5, 8'h00, 0);
        mchk(9'h001, 9'h005, 8'ha5);
        run(OP_WRITE, 0, 9'h001, 9'h006, 8'h00, 8'h00, 0);
        run(OP_MASK_NP, 0, 9'h001, 9'h006, 8'hff, 8'h0f, 0);
        mchk(9'h001, 9'h006, 8'h0f);
        run(OP_WRITE, 0, 9'h001, 9'h006, 8'hf0, 8'h0f, 0);
        mchk(9'h001, 9'h006, 8'hf0);
        run(OP_LOAD_MASK, 0, 9'h001, 9'h000, 8'h3c, 8'h00, 0);
        mchk(9'h001, 9'h000, 8'hxx);
        run(OP_MASK_P, 0, 9'h001, 9'h006, 8'h0f, 8'hff, 0);
        mchk(9'h001, 9'h006, 8'hcc);
        run(OP_MASK_P, 0, 9'h001, 9'h006, 8'hff, 8'h00, 0);
        mchk(9'h001, 9'h006, 8'hfc);
        run(OP_WRITE, 0, 9'h002, 9'h01d, 8'h11, 8'h00, 0);
        run(OP_WRITE, 0, 9'h002, 9'h020, 8'hff, 8'h00, 0);
        run(OP_LOAD_COLOR, 0, 9'h002, 9'h000, 8'h5a, 8'h00, 0);
        run(OP_BLOCK, 0, 9'h002, 9'h01f, 8'h0d, 8'h00, 0);
        for (n = 0; n < 4; n++) mchk(9'h002, 9'h01c + n[8:0], n == 1 ? 8'h11 : 8'h5a);
        run(OP_BLOCK, 1, 9'h002, 9'h022, 8'h01, 8'h0f, 0);
        mchk(9'h002, 9'h020, 8'hfa);
        // Fill the serial FIFO while the far side stalls, then drain it
        ser_to_dev <= 1'b1;
        wr_valid <= 1'b1;
        n = 0;
        repeat (40) begin
            @(posedge clk);
            if (wr_ready === 1'b1) n++;
            wr_data <= 8'h80 + n[7:0];
        end
        wr_valid <= 1'b0;
        chk(n, FIFO_DEPTH);
        p0 = vsc_vram_model_i.ptr;
        ser_run <= 1'b1;
        for (i = 0; i < 3000 && half_cross_q !== 1'b1; i++) @(posedge clk);
        if (i == 3000) hang();
        repeat (2) @(posedge clk);
        chk(half_q, 1'b1);
        chk(wr_ready, 1'b1);
        for (n = 0; n < 32; n++) chk(vsc_vram_model_i.sbuf[p0 + n], 8'h80 + n[7:0]);
        chk(vsc_vram_model_i.sbuf[p0 + 32], p0 + 32);
        ser_run <= 1'b0;
        chk(vsc_vram_model_i.viol, 0);
        summarize();
    end
endmodule
`default_nettype wire
